// ---- logic/udbp_top.sv ----
// UART data buffer port: APB registers, reload timer, transmitter, receiver.
// Assumes an APB master on clk_sys_i and serial_rx_i synchronous to it.
// Overview of operation
// - One buffer index: writes go to transmit side, reads come from receive latch.
// - Written byte queued in a 16-entry FIFO, then held in transmit shift register until shifted out.
// - Every byte write starts a serial transmission, no start command.
// - Buffer reads return receive latch, never the pending transmit byte.
// - Buffer is eight bits, bit 7 most significant, resets to zero.
// - Transmit done flag set at start of stop bit; software clears it.
// - At mid stop bit sample, latch loads only if receive flag clear and filter passes.
// - Bit rate is half the overflow rate of an 8-bit reload timer.
`timescale 1ns/1ps
module udbp_top (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic serial_tx_o,
  input wire logic serial_rx_i
);
  typedef struct packed {
    logic [7:0] receive_latch;
    logic received_extra_bit;
    logic transmit_done_flag;
    logic receive_done_flag;
    logic receive_filter_enable;
    logic rx_enable;
    logic nine_bit_mode;
    logic tx_ninth_bit;
    logic [7:0] reload_timer_high_byte;
    logic [7:0] timer;
    udbp_pkg::udbp_tx_state_t tx_state;
    logic tx_phase;
    logic [8:0] tx_shift;
    logic [3:0] tx_count;
    logic tx_line;
    udbp_pkg::udbp_rx_state_t rx_state;
    logic rx_phase;
    logic [7:0] rx_shift;
    logic rx_ninth;
    logic [3:0] rx_count;
    logic rx_line_prev;
    logic [31:0] prdata;
    logic pslverr;
  } udbp_state_t;

  udbp_state_t st;
  udbp_state_t next_st;

  logic overflow;
  logic hit_data;
  logic hit_ctrl;
  logic hit_reload;
  logic access;
  logic wr_en;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic tx_take;
  logic rx_extra;

  function automatic logic reg_hit(input logic [31:0] addr, input logic [29:0] idx);
    reg_hit = (addr[31:2] == idx);
  endfunction

  assign hit_data = reg_hit(paddr_i, udbp_pkg::UDBP_IDX_DATA_BUFFER);
  assign hit_ctrl = reg_hit(paddr_i, udbp_pkg::UDBP_IDX_CONTROL);
  assign hit_reload = reg_hit(paddr_i, udbp_pkg::UDBP_IDX_RELOAD);
  assign access = psel_i && penable_i;
  // Stall a buffer write while the transmit queue is full
  assign pready_o = !(hit_data && pwrite_i && !fifo_in_ready);
  assign wr_en = access && pwrite_i && pready_o;
  assign fifo_in_valid = access && pwrite_i && hit_data;
  assign prdata_o = st.prdata;
  assign pslverr_o = st.pslverr;
  assign serial_tx_o = st.tx_line;
  assign overflow = (st.timer == udbp_pkg::UDBP_TIMER_TOP);
  assign tx_take = fifo_out_valid && (st.tx_state == udbp_pkg::UDBP_TX_IDLE);

  // Queued writes keep their order; software should still pace on done flag
  udbp_fifo #(
    .WIDTH(udbp_pkg::UDBP_FIFO_WIDTH),
    .DEPTH(udbp_pkg::UDBP_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .in_valid_i(fifo_in_valid),
    .in_data_i(pwdata_i[7:0]),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(tx_take)
  );

  always_comb begin
    next_st = st;
    rx_extra = 1'b0;
    // Line history so a start needs a falling edge, not a low level
    next_st.rx_line_prev = serial_rx_i;

    // Read data captured in the setup phase
    if (psel_i && !penable_i) begin
      next_st.prdata = '0;
      next_st.pslverr = 1'b0;
      if (hit_data) begin
        next_st.prdata[7:0] = st.receive_latch;
      end else if (hit_ctrl) begin
        next_st.prdata[udbp_pkg::UDBP_BIT_RECEIVE_DONE] = st.receive_done_flag;
        next_st.prdata[udbp_pkg::UDBP_BIT_TRANSMIT_DONE] = st.transmit_done_flag;
        next_st.prdata[udbp_pkg::UDBP_BIT_EXTRA] = st.received_extra_bit;
        next_st.prdata[udbp_pkg::UDBP_BIT_TX_NINTH] = st.tx_ninth_bit;
        next_st.prdata[udbp_pkg::UDBP_BIT_RX_ENABLE] = st.rx_enable;
        next_st.prdata[udbp_pkg::UDBP_BIT_FILTER] = st.receive_filter_enable;
        next_st.prdata[udbp_pkg::UDBP_BIT_NINE_MODE] = st.nine_bit_mode;
      end else if (hit_reload) begin
        next_st.prdata[7:0] = st.reload_timer_high_byte;
      end else begin
        next_st.pslverr = 1'b1;
      end
    end

    // Register writes; hardware flag sets below take priority
    if (wr_en && hit_ctrl) begin
      next_st.receive_done_flag = pwdata_i[udbp_pkg::UDBP_BIT_RECEIVE_DONE];
      next_st.transmit_done_flag = pwdata_i[udbp_pkg::UDBP_BIT_TRANSMIT_DONE];
      next_st.tx_ninth_bit = pwdata_i[udbp_pkg::UDBP_BIT_TX_NINTH];
      next_st.rx_enable = pwdata_i[udbp_pkg::UDBP_BIT_RX_ENABLE];
      next_st.receive_filter_enable = pwdata_i[udbp_pkg::UDBP_BIT_FILTER];
      next_st.nine_bit_mode = pwdata_i[udbp_pkg::UDBP_BIT_NINE_MODE];
    end else if (wr_en && hit_reload) begin
      next_st.reload_timer_high_byte = pwdata_i[7:0];
    end

    // Reload timer: overflow rate is clock / (256 - reload)
    if (overflow) begin
      next_st.timer = st.reload_timer_high_byte;
    end else begin
      next_st.timer = st.timer + 1'b1;
    end

    // Transmitter: each bit lasts two timer overflows
    case (st.tx_state)
      udbp_pkg::UDBP_TX_IDLE: begin
        next_st.tx_line = 1'b1;
        if (tx_take) begin
          next_st.tx_shift = {st.tx_ninth_bit, fifo_out_data};
          next_st.tx_state = udbp_pkg::UDBP_TX_START;
          next_st.tx_phase = 1'b0;
          next_st.tx_line = 1'b0;
        end
      end
      default: begin
        if (overflow) begin
          next_st.tx_phase = !st.tx_phase;
          if (st.tx_phase) begin
            case (st.tx_state)
              udbp_pkg::UDBP_TX_START: begin
                next_st.tx_state = udbp_pkg::UDBP_TX_DATA;
                next_st.tx_count = '0;
                next_st.tx_line = st.tx_shift[0];
              end
              udbp_pkg::UDBP_TX_DATA: begin
                next_st.tx_shift = {1'b0, st.tx_shift[8:1]};
                next_st.tx_line = st.tx_shift[1];
                next_st.tx_count = st.tx_count + 1'b1;
                if (st.tx_count == udbp_pkg::UDBP_LAST_DATA_BIT) begin
                  if (st.nine_bit_mode) begin
                    next_st.tx_state = udbp_pkg::UDBP_TX_NINTH;
                  end else begin
                    next_st.tx_state = udbp_pkg::UDBP_TX_STOP;
                    next_st.tx_line = 1'b1;
                    next_st.transmit_done_flag = 1'b1;
                  end
                end
              end
              udbp_pkg::UDBP_TX_NINTH: begin
                next_st.tx_state = udbp_pkg::UDBP_TX_STOP;
                next_st.tx_line = 1'b1;
                next_st.transmit_done_flag = 1'b1;
              end
              default: begin
                next_st.tx_state = udbp_pkg::UDBP_TX_IDLE;
                next_st.tx_line = 1'b1;
              end
            endcase
          end
        end
      end
    endcase

    // Receiver: first sample mid start bit, then every two overflows
    case (st.rx_state)
      udbp_pkg::UDBP_RX_IDLE: begin
        if (st.rx_enable && st.rx_line_prev && !serial_rx_i) begin
          next_st.rx_state = udbp_pkg::UDBP_RX_START;
          next_st.rx_phase = 1'b1;
        end
      end
      default: begin
        if (overflow) begin
          next_st.rx_phase = !st.rx_phase;
          if (st.rx_phase) begin
            case (st.rx_state)
              udbp_pkg::UDBP_RX_START: begin
                next_st.rx_count = '0;
                if (serial_rx_i) begin
                  next_st.rx_state = udbp_pkg::UDBP_RX_IDLE;
                end else begin
                  next_st.rx_state = udbp_pkg::UDBP_RX_DATA;
                end
              end
              udbp_pkg::UDBP_RX_DATA: begin
                next_st.rx_shift = {serial_rx_i, st.rx_shift[7:1]};
                next_st.rx_count = st.rx_count + 1'b1;
                if (st.rx_count == udbp_pkg::UDBP_LAST_DATA_BIT) begin
                  if (st.nine_bit_mode) begin
                    next_st.rx_state = udbp_pkg::UDBP_RX_NINTH;
                  end else begin
                    next_st.rx_state = udbp_pkg::UDBP_RX_STOP;
                  end
                end
              end
              udbp_pkg::UDBP_RX_NINTH: begin
                next_st.rx_ninth = serial_rx_i;
                next_st.rx_state = udbp_pkg::UDBP_RX_STOP;
              end
              default: begin
                rx_extra = st.nine_bit_mode ? st.rx_ninth : serial_rx_i;
                // Overrun keeps the earlier byte
                if (!st.receive_done_flag && (!st.receive_filter_enable || rx_extra)) begin
                  next_st.receive_latch = st.rx_shift;
                  next_st.received_extra_bit = rx_extra;
                  next_st.receive_done_flag = 1'b1;
                end
                next_st.rx_state = udbp_pkg::UDBP_RX_IDLE;
              end
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st <= '0;
      st.receive_latch <= udbp_pkg::UDBP_RST_DATA_BUFFER;
      st.tx_shift <= '0;
      st.reload_timer_high_byte <= udbp_pkg::UDBP_RST_RELOAD;
      st.transmit_done_flag <= udbp_pkg::UDBP_RST_FLAG;
      st.receive_done_flag <= udbp_pkg::UDBP_RST_FLAG;
      st.tx_state <= udbp_pkg::UDBP_TX_IDLE;
      st.rx_state <= udbp_pkg::UDBP_RX_IDLE;
      st.tx_line <= 1'b1;
      st.rx_line_prev <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
endmodule // udbp_top

// ---- logic/udbp_pkg.sv ----
// Constants, register map and state codes of the UART data buffer port.
// Assumes a 32-bit APB master and a byte-wide register index per word.
package udbp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [29:0] UDBP_IDX_DATA_BUFFER = 30'h0000_0099;
  localparam logic [29:0] UDBP_IDX_CONTROL = 30'h0000_0098;
  localparam logic [29:0] UDBP_IDX_RELOAD = 30'h0000_008d;

  // Reset values
  localparam logic [7:0] UDBP_RST_DATA_BUFFER = 8'h00;
  localparam logic [7:0] UDBP_RST_RELOAD = 8'h00;
  localparam logic UDBP_RST_FLAG = 1'b0;

  // Control register field positions
  localparam int UDBP_BIT_RECEIVE_DONE = 0;
  localparam int UDBP_BIT_TRANSMIT_DONE = 1;
  localparam int UDBP_BIT_EXTRA = 2;
  localparam int UDBP_BIT_TX_NINTH = 3;
  localparam int UDBP_BIT_RX_ENABLE = 4;
  localparam int UDBP_BIT_FILTER = 5;
  localparam int UDBP_BIT_NINE_MODE = 7;

  // Timer and bit framing
  localparam logic [7:0] UDBP_TIMER_TOP = 8'hff;
  localparam logic [3:0] UDBP_LAST_DATA_BIT = 4'h7;

  // Transmit buffer shape
  localparam int UDBP_FIFO_WIDTH = 8;
  localparam int UDBP_FIFO_DEPTH = 16;

  typedef enum logic [2:0] {
    UDBP_TX_IDLE = 3'b000,
    UDBP_TX_START = 3'b001,
    UDBP_TX_DATA = 3'b010,
    UDBP_TX_NINTH = 3'b011,
    UDBP_TX_STOP = 3'b100
  } udbp_tx_state_t;

  typedef enum logic [2:0] {
    UDBP_RX_IDLE = 3'b000,
    UDBP_RX_START = 3'b001,
    UDBP_RX_DATA = 3'b010,
    UDBP_RX_NINTH = 3'b011,
    UDBP_RX_STOP = 3'b100
  } udbp_rx_state_t;
endpackage

// ---- logic/udbp_fifo.sv ----
// Byte FIFO with valid/ready on both sides and a registered read port.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module udbp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } udbp_fifo_state_t;

  udbp_fifo_state_t st;
  udbp_fifo_state_t next_st;
  logic push;
  logic load;

  assign in_ready_o = (st.count != FULL_COUNT);
  assign out_valid_o = st.out_valid;
  assign out_data_o = st.out_data;

  always_comb begin
    next_st = st;
    push = in_valid_i && in_ready_o;
    load = (st.count != '0) && (!st.out_valid || out_ready_i);
    if (st.out_valid && out_ready_i) begin
      next_st.out_valid = 1'b0;
    end
    if (push) begin
      next_st.mem[st.wr_ptr] = in_data_i;
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    // Output register refilled from the oldest stored word
    if (load) begin
      next_st.out_data = st.mem[st.rd_ptr];
      next_st.out_valid = 1'b1;
      next_st.rd_ptr = st.rd_ptr + 1'b1;
    end
    if (push && !load) begin
      next_st.count = st.count + 1'b1;
    end else if (load && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // udbp_fifo

// ---- dv/udbp_peer.sv ----
// Remote serial peer: frames bytes onto the rx line, collects tx bytes.
// Assumes one overflow lasts OVF clocks and tx bytes have bit 0 set.
`timescale 1ns/1ps
module udbp_peer #(
  parameter int OVF = 16
) (
  input wire logic clk_sys_i,
  input wire logic line_i,
  output logic line_o
);
  logic [7:0] got[$];
  logic [7:0] sh;
  initial line_o = 1'b1;
  // Rise after start bit marks the bit grid
  always begin
    @(negedge line_i);
    @(posedge line_i);
    for (int i = 0; i < 8; i++) begin
      repeat (i == 0 ? OVF : 2 * OVF) @(negedge clk_sys_i);
      sh[i] = line_i;
    end
    got.push_back(sh);
    wait (line_i === 1'b1);
  end
  // Bit after data is stop (8-bit) or ninth bit (9-bit); then one high bit
  task automatic send_byte(input logic [7:0] d, input logic stop);
    logic [10:0] f;
    f = {1'b1, stop, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_o <= f[i];
      repeat (2 * OVF) @(posedge clk_sys_i);
    end
    line_o <= 1'b1;
  endtask
endmodule // udbp_peer

// ---- dv/udbp_top_sva.sv ----
// Checker for the data buffer port, bound to udbp_top.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
module udbp_top_sva (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic serial_tx_o,
  input wire logic serial_rx_i
);
  logic [12:0] hi_cnt;
  logic wrote;
  logic db_sel;
  logic mapped;
  logic setup;
  logic db_wr;
  assign db_sel = paddr_i[31:2] == udbp_pkg::UDBP_IDX_DATA_BUFFER;
  assign mapped = db_sel || paddr_i[31:2] == udbp_pkg::UDBP_IDX_CONTROL
    || paddr_i[31:2] == udbp_pkg::UDBP_IDX_RELOAD;
  assign setup = psel_i && !penable_i;
  assign db_wr = psel_i && penable_i && pready_o && pwrite_i && db_sel;
  // Idle line detector: longer high than any frame
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      hi_cnt <= 13'h0;
      wrote <= 1'b0;
    end else begin
      hi_cnt <= !serial_tx_o ? 13'h0 : (hi_cnt == 13'h1fff ? hi_cnt : hi_cnt + 13'h1);
      wrote <= wrote || db_wr;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_unmapped_refused: assert property (setup && !pwrite_i && !mapped |=> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_no_err: assert property (setup && mapped |=> !pslverr_o)
    else $error("mapped access flagged");
  a_upper_zero: assert property (setup |=> prdata_o[31:8] == 24'h0)
    else $error("read data above byte not zero");
  a_wait_hold: assert property (psel_i && penable_i && !pready_o |=> $stable(prdata_o) && $stable(pslverr_o))
    else $error("answer moved during wait");
  a_stall_only_buffer: assert property (!pready_o |-> pwrite_i && db_sel)
    else $error("wait on other access");
  a_read_no_wait: assert property (psel_i && !pwrite_i |-> pready_o)
    else $error("read delayed");
  a_tx_idle_reset: assert property ($fell(rst_i) |-> serial_tx_o [*2])
    else $error("tx line not idle after reset");
  a_write_starts: assert property (db_wr && (!wrote || hi_cnt > 13'h1644) |-> ##[1:6] !serial_tx_o)
    else $error("write did not start a frame");
endmodule // udbp_top_sva
bind udbp_top udbp_top_sva u_sva (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .serial_tx_o(serial_tx_o), .serial_rx_i(serial_rx_i));

// ---- dv/tb_uart_data_buffer_port.sv ----
// Self-checking bench: APB register traffic against a serial peer.
// Assumes udbp_top, udbp_peer and the bound checker.
`timescale 1ns/1ps
module tb_uart_data_buffer_port;
  localparam logic [29:0] DB = udbp_pkg::UDBP_IDX_DATA_BUFFER;
  localparam logic [29:0] CT = udbp_pkg::UDBP_IDX_CONTROL;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, tx, rx, err;
  int n_fail = 0, cmp_count = 0, wt, mw;
  always #5 clk_sys_i = ~clk_sys_i;
  udbp_top dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .serial_tx_o(tx), .serial_rx_i(rx));
  udbp_peer #(.OVF(16)) pm (.clk_sys_i(clk_sys_i), .line_i(tx), .line_o(rx));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [29:0] idx, input logic [7:0] d);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk_sys_i);
    penable <= 1'b1;
    wt = 0;
    @(posedge clk_sys_i);
    while (pready !== 1'b1) begin
      @(posedge clk_sys_i);
      wt++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_got(input int k);
    while (pm.got.size() < k) begin
      @(posedge clk_sys_i);
    end
  endtask
  task automatic rx_case(input logic [7:0] d, input logic s, input logic [31:0] f, e);
    pm.send_byte(d, s);
    repeat (40) @(posedge clk_sys_i);
    apb(1'b0, CT, 8'h00);
    chk("rx flag", rd & 32'h1, f);
    apb(1'b0, DB, 8'h00);
    chk("rx latch", rd, e);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    apb(1'b0, DB, 8'h00);
    chk("buffer reset", rd, 32'h0);
    apb(1'b0, 30'h3f, 8'h00);
    chk("unmapped error", {31'h0, err}, 32'h1);
    apb(1'b1, udbp_pkg::UDBP_IDX_RELOAD, 8'hf0);
    apb(1'b1, DB, 8'ha5);
    apb(1'b0, CT, 8'h00);
    chk("tx flag early", rd & 32'h2, 32'h0);
    apb(1'b0, DB, 8'h00);
    chk("read not tx", rd, 32'h0);
    wait_got(1);
    repeat (40) @(posedge clk_sys_i);
    apb(1'b0, CT, 8'h00);
    chk("tx flag set", rd & 32'h2, 32'h2);
    chk("tx byte", {24'h0, pm.got[0]}, 32'ha5);
    apb(1'b1, CT, 8'h10);
    mw = 0;
    for (int i = 0; i < 20; i++) begin
      apb(1'b1, DB, 8'(i * 6 + 1));
      if (wt > mw) mw = wt;
    end
    chk("fifo stall", {31'h0, mw > 0}, 32'h1);
    wait_got(21);
    for (int i = 0; i < 20; i++) chk("tx order", {24'h0, pm.got[i + 1]}, 32'(i * 6 + 1));
    rx_case(8'h5c, 1'b1, 32'h1, 32'h5c);
    rx_case(8'h77, 1'b1, 32'h1, 32'h5c);
    apb(1'b1, CT, 8'h30);
    rx_case(8'h12, 1'b0, 32'h0, 32'h5c);
    rx_case(8'h13, 1'b1, 32'h1, 32'h13);
    apb(1'b1, CT, 8'h90);
    rx_case(8'h3c, 1'b0, 32'h1, 32'h3c);
    apb(1'b0, CT, 8'h00);
    chk("rx ninth bit", rd & 32'h4, 32'h0);
    apb(1'b1, CT, 8'hb0);
    rx_case(8'h3e, 1'b0, 32'h0, 32'h3c);
    rx_case(8'h3f, 1'b1, 32'h1, 32'h3f);
    report_and_stop();
  end
endmodule // tb_uart_data_buffer_port
